//--- hdl/pin_cfg_pkg.sv
// Constants, field layout and codes for the port pin mode and drive block
// What this block does
// - Pull/direction bits 9:8: 00 input, 01 input with pull-up, 10 input pull-down.
// - Pull/direction code 11 turns both pulls off and, with function 0, makes the pad an output.
// - Pull/direction resets to 0x2: input with pull-down after reset.
// - Function select at bits 4:0, read/write, resets to 0x0, shared code table.
// - Function 0 is plain GPIO; pad direction follows pull/direction field.
// - Function 15 is analog input on capable pins; pull/direction ignored there.
// - Same input function on several pins: lowest-numbered pin feeds the peripheral.
// - Drive register bits 11:0, bit x belongs to port pin x.
// - Drive bit 0 normal, 1 reduced drive; all bits reset to 0x0.
`default_nettype none

package pin_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_PINS  = 8;
	localparam int FIRST_PIN = 4;
	localparam int PORT_PINS = 12;
	localparam int NUM_FUNCS = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [31:0] PIN4_MODE_IDX  = 32'h5000300e;
	localparam logic [31:0] PIN5_MODE_IDX  = 32'h50003010;
	localparam logic [31:0] PIN6_MODE_IDX  = 32'h50003012;
	localparam logic [31:0] PIN7_MODE_IDX  = 32'h50003014;
	localparam logic [31:0] PIN8_MODE_IDX  = 32'h50003016;
	localparam logic [31:0] PIN9_MODE_IDX  = 32'h50003018;
	localparam logic [31:0] PIN10_MODE_IDX = 32'h5000301a;
	localparam logic [31:0] PIN11_MODE_IDX = 32'h5000301c;
	localparam logic [31:0] PAD_DRIVE_IDX  = 32'h5000301e;
	localparam logic [31:0] MODE_IDX [NUM_PINS] = '{
		PIN4_MODE_IDX, PIN5_MODE_IDX, PIN6_MODE_IDX, PIN7_MODE_IDX,
		PIN8_MODE_IDX, PIN9_MODE_IDX, PIN10_MODE_IDX, PIN11_MODE_IDX
	};
	// Only haddr[11:2] is decoded; hsel picks the block
	localparam int DEC_W = 10;

	////////////////////////////////////////////////////////////////////////////////
	// Fields and reset values
	localparam int PULL_DIR_LSB = 8;
	localparam int PULL_DIR_W   = 2;
	localparam int FUNC_LSB     = 0;
	localparam int FUNC_W       = 5;
	localparam int DRV_LSB      = 0;
	localparam int DRV_W        = 12;
	localparam logic [PULL_DIR_W-1:0] PULL_DIR_RST = 2'h2;
	localparam logic [FUNC_W-1:0]     FUNC_RST     = 5'h00;
	localparam logic [DRV_W-1:0]      DRV_RST      = 12'h000;

	typedef enum logic [1:0] {
		PULL_IN_NONE = 2'b00,
		PULL_IN_UP   = 2'b01,
		PULL_IN_DOWN = 2'b10,
		PULL_OUT     = 2'b11
	} pull_dir_t;

	localparam logic [FUNC_W-1:0] FUNC_GPIO = 5'h00;
	localparam logic [FUNC_W-1:0] FUNC_ADC  = 5'h0f;
	// Port pins with an analog path
	localparam logic [PORT_PINS-1:0] ADC_CAPABLE = 12'h0c6;

	////////////////////////////////////////////////////////////////////////////////
	// Bus codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'b0;
	localparam logic [3:0] SLOT_DRIVE    = 4'h8;
	localparam logic [3:0] SLOT_NONE     = 4'hf;

endpackage : pin_cfg_pkg

`default_nettype wire

//--- hdl/pin_slice_if.sv
// Bundle between the register core and one pin slice
`default_nettype none

interface pin_slice_if;
	pin_cfg_pkg::pull_dir_t                  pull_direction_select;
	logic [pin_cfg_pkg::FUNC_W-1:0]          pin_function_select;
	logic                                    gpio_out;
	logic [pin_cfg_pkg::NUM_FUNCS-1:0]       periph_out;
	logic [pin_cfg_pkg::NUM_FUNCS-1:0]       periph_oe;
	logic                                    pad_out;
	logic                                    pad_oe;
	logic                                    pull_up;
	logic                                    pull_down;
	logic                                    analog_en;

	modport core (
		output pull_direction_select, pin_function_select, gpio_out, periph_out, periph_oe,
		input  pad_out, pad_oe, pull_up, pull_down, analog_en
	);
	modport slice (
		input  pull_direction_select, pin_function_select, gpio_out, periph_out, periph_oe,
		output pad_out, pad_oe, pull_up, pull_down, analog_en
	);
endinterface : pin_slice_if

`default_nettype wire

//--- hdl/pin_slice.sv
// One pin: turns mode fields into registered pad controls
`default_nettype none

module pin_slice #(
	parameter logic ADC_OK = 1'b0
) (
	// Clock and reset
	input  wire logic  hclk,
	input  wire logic  hresetn,
	// Configuration and pad controls
	pin_slice_if.slice s
);

	logic n_out;
	logic n_oe;
	logic n_up;
	logic n_dn;
	logic n_an;

	always_comb begin
		n_out = 1'b0;
		n_oe  = 1'b0;
		n_up  = 1'b0;
		n_dn  = 1'b0;
		n_an  = 1'b0;
		if (ADC_OK && s.pin_function_select == pin_cfg_pkg::FUNC_ADC) begin
			n_an = 1'b1;
		end else begin
			n_up = (s.pull_direction_select == pin_cfg_pkg::PULL_IN_UP);
			n_dn = (s.pull_direction_select == pin_cfg_pkg::PULL_IN_DOWN);
			if (s.pin_function_select == pin_cfg_pkg::FUNC_GPIO) begin
				n_oe  = (s.pull_direction_select == pin_cfg_pkg::PULL_OUT);
				n_out = s.gpio_out;
			end else begin
				// Peripheral decides its own direction
				n_oe  = s.periph_oe[s.pin_function_select];
				n_out = s.periph_out[s.pin_function_select];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s.pad_out   <= 1'b0;
			s.pad_oe    <= 1'b0;
			s.pull_up   <= 1'b0;
			s.pull_down <= 1'b1;
			s.analog_en <= 1'b0;
		end else begin
			s.pad_out   <= n_out;
			s.pad_oe    <= n_oe;
			s.pull_up   <= n_up;
			s.pull_down <= n_dn;
			s.analog_en <= n_an;
		end
	end

endmodule : pin_slice

`default_nettype wire

//--- hdl/pin_mode_cfg.sv
// Port pin mode and drive registers on AHB-Lite, with pin routing
`default_nettype none

module pin_mode_cfg (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Pads of port pins 4 to 11
	input  wire logic [7:0]  pad_in,
	output logic      [7:0]  pad_out,
	output logic      [7:0]  pad_oe,
	output logic      [7:0]  pad_pull_up,
	output logic      [7:0]  pad_pull_down,
	output logic      [7:0]  pad_analog_en,
	// Drive strength of port pins 0 to 11
	output logic      [11:0] pad_reduced_drive,
	// GPIO side
	input  wire logic [7:0]  gpio_out,
	output logic      [7:0]  gpio_in,
	// Peripheral side, indexed by function code
	input  wire logic [31:0] periph_out,
	input  wire logic [31:0] periph_oe,
	output logic      [31:0] periph_in
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	pin_cfg_pkg::pull_dir_t         pull_dir_reg [pin_cfg_pkg::NUM_PINS];
	pin_cfg_pkg::pull_dir_t         pull_dir_next [pin_cfg_pkg::NUM_PINS];
	logic [pin_cfg_pkg::FUNC_W-1:0] func_sel_reg [pin_cfg_pkg::NUM_PINS];
	logic [pin_cfg_pkg::FUNC_W-1:0] func_sel_next [pin_cfg_pkg::NUM_PINS];
	logic [pin_cfg_pkg::DRV_W-1:0]  drive_reg;
	logic [pin_cfg_pkg::DRV_W-1:0]  drive_next;
	logic                           wr_pend_reg;
	logic [3:0]                     wr_slot_reg;
	logic [3:0]                     addr_slot;
	logic                           take;
	logic [31:0]                    rdata_next;
	logic [31:0]                    periph_in_next;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb begin
		addr_slot = pin_cfg_pkg::SLOT_NONE;
		for (int i = 0; i < pin_cfg_pkg::NUM_PINS; i++) begin
			if (haddr[11:2] == pin_cfg_pkg::MODE_IDX[i][pin_cfg_pkg::DEC_W-1:0]) begin
				addr_slot = 4'(i);
			end
		end
		if (haddr[11:2] == pin_cfg_pkg::PAD_DRIVE_IDX[pin_cfg_pkg::DEC_W-1:0]) begin
			addr_slot = pin_cfg_pkg::SLOT_DRIVE;
		end
	end

	// Only word transfers are honoured; narrower sizes are ignored
	assign take = hsel && hready && htrans == pin_cfg_pkg::HTRANS_NONSEQ
		&& hsize == pin_cfg_pkg::HSIZE_WORD;

	// Never stalls, never errors
	assign hreadyout = 1'b1;
	assign hresp     = pin_cfg_pkg::HRESP_OKAY;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_slot_reg <= pin_cfg_pkg::SLOT_NONE;
		end else begin
			wr_pend_reg <= take && hwrite;
			wr_slot_reg <= addr_slot;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write path: data phase carries hwdata

	always_comb begin
		drive_next = drive_reg;
		for (int i = 0; i < pin_cfg_pkg::NUM_PINS; i++) begin
			pull_dir_next[i] = pull_dir_reg[i];
			func_sel_next[i] = func_sel_reg[i];
			if (wr_pend_reg && wr_slot_reg == 4'(i)) begin
				// Bits 31:10 and 7:5 are dropped
				pull_dir_next[i] = pin_cfg_pkg::pull_dir_t'(
					hwdata[pin_cfg_pkg::PULL_DIR_LSB +: pin_cfg_pkg::PULL_DIR_W]);
				func_sel_next[i] = hwdata[pin_cfg_pkg::FUNC_LSB +: pin_cfg_pkg::FUNC_W];
			end
		end
		if (wr_pend_reg && wr_slot_reg == pin_cfg_pkg::SLOT_DRIVE) begin
			drive_next = hwdata[pin_cfg_pkg::DRV_LSB +: pin_cfg_pkg::DRV_W];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < pin_cfg_pkg::NUM_PINS; i++) begin
				pull_dir_reg[i] <= pin_cfg_pkg::pull_dir_t'(pin_cfg_pkg::PULL_DIR_RST);
				func_sel_reg[i] <= pin_cfg_pkg::FUNC_RST;
			end
		end else begin
			for (int i = 0; i < pin_cfg_pkg::NUM_PINS; i++) begin
				pull_dir_reg[i] <= pull_dir_next[i];
				func_sel_reg[i] <= func_sel_next[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_reg <= pin_cfg_pkg::DRV_RST;
		end else begin
			drive_reg <= drive_next;
		end
	end

	// Bit x reduces the drive of port pin x
	assign pad_reduced_drive = drive_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Read path: sampled at the address phase from the next values,
	// so a read right behind a write sees the new contents

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (take && !hwrite) begin
			for (int i = 0; i < pin_cfg_pkg::NUM_PINS; i++) begin
				if (addr_slot == 4'(i)) begin
					rdata_next[pin_cfg_pkg::PULL_DIR_LSB +: pin_cfg_pkg::PULL_DIR_W] = pull_dir_next[i];
					rdata_next[pin_cfg_pkg::FUNC_LSB +: pin_cfg_pkg::FUNC_W] = func_sel_next[i];
				end
			end
			if (addr_slot == pin_cfg_pkg::SLOT_DRIVE) begin
				rdata_next[pin_cfg_pkg::DRV_LSB +: pin_cfg_pkg::DRV_W] = drive_next;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else begin
			hrdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin slices

	for (genvar g = 0; g < pin_cfg_pkg::NUM_PINS; g++) begin : g_pin
		pin_slice_if ps ();

		assign ps.pull_direction_select = pull_dir_reg[g];
		assign ps.pin_function_select   = func_sel_reg[g];
		assign ps.gpio_out   = gpio_out[g];
		assign ps.periph_out = periph_out;
		assign ps.periph_oe  = periph_oe;

		pin_slice #(
			.ADC_OK (pin_cfg_pkg::ADC_CAPABLE[g + pin_cfg_pkg::FIRST_PIN])
		) u_slice (
			.hclk    (hclk),
			.hresetn (hresetn),
			.s       (ps.slice)
		);

		assign pad_out[g]       = ps.pad_out;
		assign pad_oe[g]        = ps.pad_oe;
		assign pad_pull_up[g]   = ps.pull_up;
		assign pad_pull_down[g] = ps.pull_down;
		assign pad_analog_en[g] = ps.analog_en;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input routing to peripherals

	always_comb begin
		periph_in_next = 32'h0000_0000;
		for (int f = 1; f < pin_cfg_pkg::NUM_FUNCS; f++) begin
			// Walk downward so the lowest pin is written last
			for (int p = pin_cfg_pkg::NUM_PINS - 1; p >= 0; p--) begin
				if (func_sel_reg[p] == 5'(f)) begin
					periph_in_next[f] = pad_in[p];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			periph_in <= 32'h0000_0000;
			gpio_in   <= 8'h00;
		end else begin
			periph_in <= periph_in_next;
			gpio_in   <= pad_in;
		end
	end

endmodule : pin_mode_cfg

`default_nettype wire

//--- bench/pin_mode_sva.sv
// Port checker for the pin mode and drive block
`default_nettype none
module pin_mode_sva (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pads and GPIO
	input wire logic [7:0]  pad_in,
	input wire logic [7:0]  pad_oe,
	input wire logic [7:0]  pad_pull_up,
	input wire logic [7:0]  pad_pull_down,
	input wire logic [7:0]  pad_analog_en,
	input wire logic [11:0] pad_reduced_drive,
	input wire logic [7:0]  gpio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic go;
	assign go = hsel && hready && htrans == pin_cfg_pkg::HTRANS_NONSEQ
		&& hsize == pin_cfg_pkg::HSIZE_WORD;
	sequence s_drv_wr;
		go && hwrite && haddr[11:0] == 12'h078 ##1 1'b1;
	endsequence
	sequence s_mode_rd;
		go && !hwrite && haddr[11:0] >= 12'h038 && haddr[11:0] <= 12'h070 ##1 1'b1;
	endsequence
	a_bus_okay: assert property (hreadyout && hresp == pin_cfg_pkg::HRESP_OKAY)
		else $error("bus answer not ready or not okay");
	a_drive_write: assert property (s_drv_wr |=> pad_reduced_drive == $past(hwdata[11:0]))
		else $error("drive bits differ from written word");
	a_mode_rsvd: assert property (s_mode_rd |-> (hrdata & 32'hffff_fce0) == 32'h0)
		else $error("reserved mode bits read nonzero");
	a_rdata_idle: assert property (!$past(go && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside a read");
	a_analog_quiet: assert property (
		(pad_analog_en & (pad_oe | pad_pull_up | pad_pull_down)) == 8'h0)
		else $error("analog pad driven or pulled");
	a_analog_pins: assert property ((pad_analog_en & ~8'h0c) == 8'h0)
		else $error("analog mode on a pin without analog path");
	a_pull_excl: assert property ((pad_pull_up & pad_pull_down) == 8'h0)
		else $error("both pulls on one pad");
	a_reset_vals: assert property ($rose(hresetn) |-> pad_pull_down == 8'hff
		&& pad_oe == 8'h0 && pad_reduced_drive == 12'h0)
		else $error("pads not at reset state");
	a_gpio_sample: assert property ($past(hresetn) |-> gpio_in == $past(pad_in))
		else $error("gpio input not one cycle behind pad");
endmodule : pin_mode_sva
bind pin_mode_cfg pin_mode_sva pin_mode_sva_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pad_in, .pad_oe,
	.pad_pull_up, .pad_pull_down, .pad_analog_en, .pad_reduced_drive, .gpio_in);
`default_nettype wire

//--- bench/pad_far_side.sv
// Board side of port pins 4 to 11
`default_nettype none
module pad_far_side (
	input  wire logic       hclk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pad_pull_up,
	input  wire logic [7:0] pad_pull_down,
	output var logic  [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Floating pads wander so a stale level is never trusted
	logic [7:0] float_reg;
	initial float_reg = 8'h5a;
	always @(posedge hclk) float_reg <= ~float_reg;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) pad_in[i] = pad_out[i];
			else if (pad_pull_up[i]) pad_in[i] = 1'b1;
			else if (pad_pull_down[i]) pad_in[i] = 1'b0;
			else pad_in[i] = float_reg[i];
		end
	end
endmodule : pad_far_side
`default_nettype wire

//--- bench/port_pin_mode_and_drive_config_bench.sv
// Self-checking bench for the pin mode and drive block
`default_nettype none
module port_pin_mode_and_drive_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int kind; string what; logic [31:0] exp;} note_t;
	note_t notes[$];
	int error_cnt = 0;
	int total_checks = 0;
	logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp, look = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, periph_out = 0, periph_oe = 0, periph_in, w;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = pin_cfg_pkg::HSIZE_WORD;
	logic [7:0] pad_in, pad_out, pad_oe, pull_up, pull_down, analog, gpio_in, gpio_out = 0;
	logic [11:0] drive;
	assign hready = hreadyout;
	pin_mode_cfg pin_mode_cfg_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .pad_in, .pad_out, .pad_oe,
		.pad_pull_up(pull_up), .pad_pull_down(pull_down), .pad_analog_en(analog),
		.pad_reduced_drive(drive), .gpio_out, .gpio_in, .periph_out, .periph_oe, .periph_in);
	pad_far_side pad_far_side_inst (.hclk, .pad_out, .pad_oe, .pad_pull_up(pull_up),
		.pad_pull_down(pull_down), .pad_in);
	initial forever #25 hclk = ~hclk;
	function automatic logic [31:0] addr(input int i);
		return (i < 8 ? pin_cfg_pkg::MODE_IDX[i] : pin_cfg_pkg::PAD_DRIVE_IDX) << 2;
	endfunction : addr
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, input string s);
		haddr <= a;
		hwrite <= wr;
		htrans <= pin_cfg_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr) notes.push_back('{0, s, d});
		look <= !wr;
		do @(posedge hclk); while (hready !== 1'b1);
		look <= 1'b0;
	endtask : xfer
	task automatic probe(input int k, input logic [31:0] e, input string s);
		repeat (2) @(posedge hclk);
		notes.push_back('{k, s, e});
		look <= 1'b1;
		@(posedge hclk);
		look <= 1'b0;
	endtask : probe
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	always @(posedge hclk) begin : watch
		note_t n;
		logic [31:0] seen;
		if (look) begin
			n = notes.pop_front();
			case (n.kind)
				0: seen = hrdata;
				1: seen = periph_in;
				2: seen = {20'h0, drive};
				default: seen = {27'h0, pad_oe[n.kind-8], pad_oe[n.kind-8] & pad_out[n.kind-8],
					pull_up[n.kind-8], pull_down[n.kind-8], analog[n.kind-8]};
			endcase
			total_checks++;
			if (seen !== n.exp) begin
				error_cnt++;
				$display("unexpected %s expected %h seen %h", n.what, n.exp, seen);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		end_of_test();
	end
	initial begin
		w = $urandom(32'haa467549);
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		probe(15, 5'h02, "pin 11 pads");
		for (int i = 0; i < 9; i++) begin
			xfer(0, addr(i), i < 8 ? 32'h200 : 32'h0, "reset value");
		end
		for (int i = 0; i < 9; i++) begin
			w = $urandom();
			xfer(1, addr(i), w, "");
			xfer(0, addr(i), w & (i < 8 ? 32'h31f : 32'hfff), "readback");
		end
		probe(2, w & 32'hfff, "drive");
		xfer(1, 32'h100, 32'hffff_ffff, "");
		xfer(0, 32'h100, 32'h0, "unmapped");
		gpio_out <= 8'($urandom());
		periph_out <= $urandom();
		periph_oe <= $urandom() & ~32'h2;
		for (int i = 0; i < 8; i++) for (int c = 0; c < 4; c++) begin
			xfer(1, addr(i), 32'(c) << 8, "");
			w = 32'({c == 3, c == 3 && gpio_out[i], c == 1, c == 2, 1'b0});
			probe(8 + i, w, "pad mode");
		end
		for (int i = 0; i < 8; i++) begin
			xfer(1, addr(i), 32'h30f, "");
			probe(8 + i, pin_cfg_pkg::ADC_CAPABLE[i+4] ? 1 : {periph_oe[15],
				periph_oe[15] & periph_out[15], 3'b000}, "func 15");
		end
		for (int i = 0; i < 8; i++) xfer(1, addr(i), 32'h200, "");
		for (int j = 7; j >= 0; j--) begin
			xfer(1, addr(j), 32'h101, "");
			probe(1, 32'h2, "lowest up");
			xfer(1, addr(j), 32'h201, "");
			probe(1, 32'h0, "lowest down");
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(0, addr(5), 32'h200, "second reset");
		end_of_test();
	end
endmodule : port_pin_mode_and_drive_config_bench
`default_nettype wire
